//--- verilog/mpsg_pkg.sv
// shared constants for the multi-plane sync glue
`default_nettype none
package mpsg_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_DEVICES     = 4;
  localparam int DATA_WIDTH      = 16;
  localparam int PLANES_PER_DEV  = 4;
  localparam int MAX_PASS_PLANES = 16;
  // ----------------------------------------
  // pixel shift settings
  // ----------------------------------------
  localparam logic [2:0] SHIFT_ONE  = 3'h1;
  localparam logic [2:0] SHIFT_TWO  = 3'h2;
  localparam logic [2:0] SHIFT_FOUR = 3'h4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0]  ACT_RESET  = 4'hf;
  // ----------------------------------------
  // transfer modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MPSG_IDLE,
    MPSG_BY_PLANE,
    MPSG_BY_PIXEL
  } mpsg_mode_e;
endpackage : mpsg_pkg
`default_nettype wire

//--- verilog/mpsg_if.sv
// wired-and glue node bundle between the devices and the host side
`timescale 1ns/1ps
`default_nettype none
interface mpsg_if #(
  parameter int N = 4
) ();
  // per device outputs; request pull enables high mean pulling low
  logic [N-1:0]    instr_fifo_dma_request_oe;
  logic [N-1:0]    data_fifo_dma_request_oe;
  logic [N-1:0]    instr_step_sync_out;
  logic [N-1:0]    display_bus_sync_out;
  logic [N-1:0]    external_driver_enable;
  logic [N*16-1:0] dev_data;
  // composites from the host glue
  logic            instr_step_sync_in;
  logic            display_bus_sync_in;
  logic            cycle_strobe;
  logic            by_pixel;
  logic            is_read;
  logic [2:0]      pixel_shift_count_field;
  logic [3:0]      plane_select;
  logic [1:0]      device_select;

  modport device (
    output instr_fifo_dma_request_oe,
    output data_fifo_dma_request_oe,
    output instr_step_sync_out,
    output display_bus_sync_out,
    output external_driver_enable,
    output dev_data,
    input  instr_step_sync_in,
    input  display_bus_sync_in,
    input  cycle_strobe,
    input  by_pixel,
    input  is_read,
    input  pixel_shift_count_field,
    input  plane_select,
    input  device_select
  );
  modport host (
    input  instr_fifo_dma_request_oe,
    input  data_fifo_dma_request_oe,
    input  instr_step_sync_out,
    input  display_bus_sync_out,
    input  external_driver_enable,
    input  dev_data,
    output instr_step_sync_in,
    output display_bus_sync_in,
    output cycle_strobe,
    output by_pixel,
    output is_read,
    output pixel_shift_count_field,
    output plane_select,
    output device_select
  );
endinterface : mpsg_if
`default_nettype wire

//--- verilog/mpsg_device_end.sv
// device-side end: the plane-processor devices' glue behaviour
//
// Overview of operation
// - request pins open-drain: pull low until ready
// - instr request for instr fifo, data both ways
// - data node low while any device unready
// - instr node low while any device unready
// - by-plane: one plane in one device
// - host reads the selected device's word only
// - non-holding device keeps driver enable off
// - holding device alone asserts driver enable, when its selected plane is active
// - by-pixel: every device contributes its planes
// - pixel shift field 1, 2 or 4
// - each device presents full 16-bit word
// - shift held word left by the field amount (1, 2 or 4) per by-pixel read cycle
// - host transceiver concatenates top 16/N bits of each device to word
// - host enables plane or pixel transceivers, not both
// - one pass handles at most 16 planes
// - instruction-step sync outputs are anded
// - composite step sync fed back to inputs
// - display sync anded and fed back likewise
// - single device ties its sync pairs too
// - inactive plane never written
`timescale 1ns/1ps
`default_nettype none
module mpsg_device_end
  import mpsg_pkg::*;
#(
  parameter int N = NUM_DEVICES
) (
  input  wire logic            i_clock,
  input  wire logic            i_reset,
  mpsg_if.device               bus,
  input  wire logic [N-1:0]    i_instr_fifo_ready,
  input  wire logic [N-1:0]    i_data_fifo_ready,
  input  wire logic [N-1:0]    i_step_ready,
  input  wire logic [N-1:0]    i_display_ready,
  input  wire logic [N*16-1:0] i_load_word,
  input  wire logic            i_load,
  input  wire logic [N*4-1:0]  i_activity,
  input  wire logic [N*4-1:0]  i_write_nibble,
  output logic [N-1:0]         o_step_go,
  output logic [N-1:0]         o_display_go,
  output logic [N*4-1:0]       o_plane_write
);
  initial begin
    if (N != 1 && N != 2 && N != 4) begin
      $error("device count must be 1, 2 or 4");
    end
  end

  // ----------------------------------------
  // per device logic
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_dev
      logic [15:0] word_reg;
      logic        req_i_reg;
      logic        req_d_reg;
      logic        ede_reg;
      logic        step_reg;
      logic        disp_reg;
      logic        go_s_reg;
      logic        go_d_reg;
      logic [3:0]  wr_reg;
      wire  [15:0] shifted;
      wire         holds;
      wire         sel_plane_act;
      wire  [3:0]  wr_next;

      // shift amount follows the programmed field, not the device count
      assign shifted = (bus.pixel_shift_count_field == SHIFT_FOUR) ? {word_reg[11:0], 4'h0} :
                       (bus.pixel_shift_count_field == SHIFT_TWO)  ? {word_reg[13:0], 2'h0} :
                       {word_reg[14:0], 1'h0};
      assign holds = (bus.device_select == 2'(g));
      assign sel_plane_act = i_activity[g*4 + 32'(bus.plane_select[1:0])];
      // plane writes gated by activity bits
      assign wr_next = !bus.cycle_strobe || bus.is_read ? 4'h0 :
                       bus.by_pixel ? i_activity[g*4 +: 4] :
                       holds ? (4'h1 << bus.plane_select[1:0]) & i_activity[g*4 +: 4] :
                       4'h0;

      always_ff @(posedge i_clock) begin
        if (i_reset) begin
          word_reg  <= WORD_RESET;
          req_i_reg <= 1'b1;
          req_d_reg <= 1'b1;
          ede_reg   <= 1'b0;
          step_reg  <= 1'b0;
          disp_reg  <= 1'b0;
          go_s_reg  <= 1'b0;
          go_d_reg  <= 1'b0;
          wr_reg    <= 4'h0;
        end else begin
          req_i_reg <= !i_instr_fifo_ready[g];
          req_d_reg <= !i_data_fifo_ready[g];
          // by-pixel reads: every device drives; by-plane reads: only the holder, when its plane is active
          ede_reg   <= bus.cycle_strobe && bus.is_read &&
                       (bus.by_pixel || (holds && sel_plane_act));
          step_reg  <= i_step_ready[g];
          disp_reg  <= i_display_ready[g];
          go_s_reg  <= bus.instr_step_sync_in;
          go_d_reg  <= bus.display_bus_sync_in;
          wr_reg    <= wr_next;
          if (i_load) begin
            word_reg <= i_load_word[g*16 +: 16];
          end else if (bus.cycle_strobe && bus.by_pixel && bus.is_read) begin
            word_reg <= shifted;
          end
        end
      end

      assign bus.instr_fifo_dma_request_oe[g] = req_i_reg;
      assign bus.data_fifo_dma_request_oe[g]  = req_d_reg;
      assign bus.external_driver_enable[g]    = ede_reg;
      assign bus.instr_step_sync_out[g]       = step_reg;
      assign bus.display_bus_sync_out[g]      = disp_reg;
      assign bus.dev_data[g*16 +: 16]         = word_reg;
      assign o_step_go[g]                     = go_s_reg;
      assign o_display_go[g]                  = go_d_reg;
      assign o_plane_write[g*4 +: 4]          = wr_reg;
    end
  endgenerate

  wire unused_ok = ^i_write_nibble;
endmodule : mpsg_device_end
`default_nettype wire

//--- verilog/mpsg_host_end.sv
// host-side glue: wired-and nodes, sync feedback, pixel word assembly
`timescale 1ns/1ps
`default_nettype none
module mpsg_host_end
  import mpsg_pkg::*;
#(
  parameter int N = NUM_DEVICES
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  mpsg_if.host             bus,
  input  wire logic        i_cycle,
  input  wire logic        i_by_pixel,
  input  wire logic        i_is_read,
  input  wire logic [1:0]  i_device_select,
  input  wire logic [3:0]  i_plane_select,
  output logic             o_host_dma_channel0_request,
  output logic             o_instr_fifo_dma_request,
  output logic             o_plane_xcvr_enable,
  output logic             o_pixel_xcvr_enable,
  output logic [15:0]      o_read_word
);
  initial begin
    if (N != 1 && N != 2 && N != 4) begin
      $error("device count must be 1, 2 or 4");
    end
  end

  // ----------------------------------------
  // wired-and composites
  // ----------------------------------------
  localparam int NIB = 16 / N;
  wire        data_node  = !(|bus.data_fifo_dma_request_oe);
  wire        instr_node = !(|bus.instr_fifo_dma_request_oe);
  wire [15:0] pixel_word;
  wire [15:0] plane_word = bus.dev_data[32'(i_device_select) * 16 +: 16];
  logic       data_fifo_dma_request_reg, instr_fifo_dma_request_reg, step_reg, disp_reg, cyc_reg, pix_reg, rd_reg;
  logic       pen_reg, xen_reg;
  logic [15:0] rd_word_reg;

  // top 16/N bits of each device, device 0 most significant
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_cat
      assign pixel_word[15 - g*NIB -: NIB] = bus.dev_data[g*16 + 15 -: NIB];
    end
  endgenerate

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      data_fifo_dma_request_reg    <= 1'b0;
      instr_fifo_dma_request_reg    <= 1'b0;
      step_reg    <= 1'b0;
      disp_reg    <= 1'b0;
      cyc_reg     <= 1'b0;
      pix_reg     <= 1'b0;
      rd_reg      <= 1'b0;
      pen_reg     <= 1'b0;
      xen_reg     <= 1'b0;
      rd_word_reg <= WORD_RESET;
    end else begin
      data_fifo_dma_request_reg <= data_node;
      instr_fifo_dma_request_reg <= instr_node;
      step_reg <= &bus.instr_step_sync_out;
      disp_reg <= &bus.display_bus_sync_out;
      cyc_reg  <= i_cycle;
      pix_reg  <= i_by_pixel;
      rd_reg   <= i_is_read;
      // one transceiver set only, chosen by access type
      pen_reg  <= i_cycle && !i_by_pixel;
      xen_reg  <= i_cycle && i_by_pixel;
      if (cyc_reg && rd_reg) begin
        rd_word_reg <= pix_reg ? pixel_word : plane_word;
      end
    end
  end

  assign o_host_dma_channel0_request  = data_fifo_dma_request_reg;
  assign o_instr_fifo_dma_request     = instr_fifo_dma_request_reg;
  assign o_plane_xcvr_enable          = pen_reg;
  assign o_pixel_xcvr_enable          = xen_reg;
  assign o_read_word                  = rd_word_reg;
  assign bus.instr_step_sync_in       = step_reg;
  assign bus.display_bus_sync_in      = disp_reg;
  assign bus.cycle_strobe             = cyc_reg;
  assign bus.by_pixel                 = pix_reg;
  assign bus.is_read                  = rd_reg;
  assign bus.device_select            = i_device_select;
  assign bus.plane_select             = i_plane_select;
  // shift fixed by fitted device count
  assign bus.pixel_shift_count_field  = (N == 4) ? SHIFT_FOUR :
                                        (N == 2) ? SHIFT_TWO : SHIFT_ONE;
endmodule : mpsg_host_end
`default_nettype wire

//--- bench/mpsg_monitor.sv
// assertion checker on the glue interface signals
`timescale 1ns/1ps
`default_nettype none
module mpsg_monitor #(
  parameter int N = 4
) (
  input  wire logic         i_clock,
  input  wire logic         i_reset,
  input  wire logic [N-1:0] instr_fifo_dma_request_oe,
  input  wire logic [N-1:0] data_fifo_dma_request_oe,
  input  wire logic [N-1:0] instr_step_sync_out,
  input  wire logic [N-1:0] display_bus_sync_out,
  input  wire logic [N-1:0] external_driver_enable,
  input  wire logic         instr_step_sync_in,
  input  wire logic         display_bus_sync_in,
  input  wire logic         cycle_strobe,
  input  wire logic         by_pixel,
  input  wire logic         is_read,
  input  wire logic [2:0]   pixel_shift_count_field,
  input  wire logic [1:0]   device_select
);
  // ------
  // properties
  // ------
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  sequence s_pixel_read;
    cycle_strobe && by_pixel && is_read;
  endsequence
  sequence s_plane_read;
    cycle_strobe && !by_pixel && is_read;
  endsequence
  a_reset_pulls: assert property (disable iff (1'b0) i_reset |=>
    (&data_fifo_dma_request_oe) && (&instr_fifo_dma_request_oe)) else $error("nodes released");
  a_step_and: assert property (instr_step_sync_in == $past(&instr_step_sync_out))
    else $error("step composite wrong");
  a_display_and: assert property (display_bus_sync_in == $past(&display_bus_sync_out))
    else $error("display composite wrong");
  a_ede_cause: assert property (|external_driver_enable |-> $past(cycle_strobe))
    else $error("driver enable without cycle");
  a_pixel_all: assert property (s_pixel_read |=> &external_driver_enable)
    else $error("pixel read missing driver");
  a_plane_single: assert property (s_plane_read |=> $onehot0(external_driver_enable))
    else $error("several drivers on plane read");
  a_plane_owner: assert property (s_plane_read |=>
    (external_driver_enable & ~(N'(1) << $past(device_select))) == '0) else $error("wrong driver");
  // software field must track the device count
  a_shift_field: assert property (pixel_shift_count_field ==
    ((N >= 4) ? 3'h4 : (N == 2) ? 3'h2 : 3'h1)) else $error("shift field wrong");
endmodule : mpsg_monitor
`default_nettype wire

//--- bench/tb_multi_plane_sync_glue.sv
// self-checking bench joining device end and host end
`timescale 1ns/1ps
`default_nettype none
module tb_multi_plane_sync_glue;
  import mpsg_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  ins_rdy = 4'h0, dat_rdy = 4'h0, stp_rdy = 4'h0, dsp_rdy = 4'h0;
  logic [15:0] act = 16'hffff;
  logic [63:0] words = 64'h0123_4567_89ab_cdef, expd;
  logic        load = 1'b0, cyc = 1'b0, pix = 1'b0, rd = 1'b0;
  logic [1:0]  dsel = 2'h0;
  logic [3:0]  psel = 4'h0, stp_go, dsp_go;
  logic [15:0] pw, rword, exp;
  logic        data_fifo_dma_request, ireq, plx, pxx;
  int          mismatches = 0, check_count = 0;
  always #10 i_clock = ~i_clock;
  mpsg_if #(.N(4)) u_mpsg_if ();
  mpsg_device_end #(.N(4)) u_mpsg_device_end (.i_clock(i_clock), .i_reset(i_reset),
    .bus(u_mpsg_if.device), .i_instr_fifo_ready(ins_rdy), .i_data_fifo_ready(dat_rdy),
    .i_step_ready(stp_rdy), .i_display_ready(dsp_rdy), .i_load_word(words), .i_load(load),
    .i_activity(act), .i_write_nibble(16'h0), .o_step_go(stp_go), .o_display_go(dsp_go),
    .o_plane_write(pw));
  mpsg_host_end #(.N(4)) u_mpsg_host_end (.i_clock(i_clock), .i_reset(i_reset),
    .bus(u_mpsg_if.host), .i_cycle(cyc), .i_by_pixel(pix), .i_is_read(rd),
    .i_device_select(dsel), .i_plane_select(psel), .o_host_dma_channel0_request(data_fifo_dma_request),
    .o_instr_fifo_dma_request(ireq), .o_plane_xcvr_enable(plx), .o_pixel_xcvr_enable(pxx),
    .o_read_word(rword));
  mpsg_monitor #(.N(4)) u_mpsg_monitor (.i_clock(i_clock), .i_reset(i_reset),
    .instr_fifo_dma_request_oe(u_mpsg_if.instr_fifo_dma_request_oe),
    .data_fifo_dma_request_oe(u_mpsg_if.data_fifo_dma_request_oe),
    .instr_step_sync_out(u_mpsg_if.instr_step_sync_out),
    .display_bus_sync_out(u_mpsg_if.display_bus_sync_out),
    .external_driver_enable(u_mpsg_if.external_driver_enable),
    .instr_step_sync_in(u_mpsg_if.instr_step_sync_in),
    .display_bus_sync_in(u_mpsg_if.display_bus_sync_in),
    .cycle_strobe(u_mpsg_if.cycle_strobe), .by_pixel(u_mpsg_if.by_pixel),
    .is_read(u_mpsg_if.is_read), .pixel_shift_count_field(u_mpsg_if.pixel_shift_count_field),
    .device_select(u_mpsg_if.device_select));
  // ------
  // tasks
  // ------
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, want, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // one bus cycle; returns just after the answer edge, while the one-cycle answers stand
  task automatic bus_cycle(input logic p, input logic r, input logic [1:0] d,
                           input logic [3:0] pl);
    @(posedge i_clock);
    {cyc, pix, rd, dsel, psel} <= {1'b1, p, r, d, pl};
    @(posedge i_clock);
    cyc <= 1'b0;
    #1;
    // transceiver enables stand only in the strobe cycle
    if (r) chk("xcvr enables", {plx, pxx}, p ? 2'b01 : 2'b10);
    @(posedge i_clock);
    #1;
  endtask : bus_cycle
  // ------
  // tests
  // ------
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      {ins_rdy, dat_rdy, stp_rdy, dsp_rdy} <= {4{~(4'h1 << k)}};
      repeat (4) @(posedge i_clock);
      #1;
      chk("data node", {data_fifo_dma_request, ireq}, 2'b00);
      chk("sync go", {stp_go, dsp_go}, 8'h00);
      @(posedge i_clock);
      {ins_rdy, dat_rdy, stp_rdy, dsp_rdy} <= 16'hffff;
      repeat (4) @(posedge i_clock);
      #1;
      chk("both nodes", {data_fifo_dma_request, ireq}, 2'b11);
      chk("sync go", {stp_go, dsp_go}, 8'hff);
    end
    $display("test nodes done");
    @(posedge i_clock);
    load <= 1'b1;
    @(posedge i_clock);
    load <= 1'b0;
    @(posedge i_clock);
    #1;
    chk("held words", u_mpsg_if.dev_data, words);
    // back to back only in the bench sense; answer latency is checked per cycle
    for (int k = 0; k < 4; k++) begin
      bus_cycle(1'b1, 1'b1, 2'h0, 4'h0);
      for (int g = 0; g < 4; g++) begin
        exp[15-4*g -: 4] = words[16*g+12-4*k +: 4];
        expd[16*g +: 16] = words[16*g +: 16] << (4 * (k + 1));
      end
      chk("pixel word", rword, exp);
      chk("pixel drivers", u_mpsg_if.external_driver_enable, 4'hf);
      chk("shifted words", u_mpsg_if.dev_data, expd);
    end
    $display("test pixel read done");
    for (int d = 0; d < 4; d++) begin
      bus_cycle(1'b0, 1'b1, d[1:0], 4'h1);
      chk("plane driver", u_mpsg_if.external_driver_enable, 4'h1 << d);
    end
    @(posedge i_clock);
    act <= 16'hfdff;
    bus_cycle(1'b0, 1'b1, 2'h2, 4'h1);
    chk("inactive driver", u_mpsg_if.external_driver_enable, 4'h0);
    $display("test plane read done");
    bus_cycle(1'b1, 1'b0, 2'h0, 4'h0);
    chk("pixel writes", pw, 16'hfdff);
    bus_cycle(1'b0, 1'b0, 2'h1, 4'h2);
    chk("plane write", pw, 16'h0040);
    bus_cycle(1'b0, 1'b0, 2'h2, 4'h1);
    chk("masked write", pw, 16'h0000);
    $display("test writes done");
    finish_test();
  end
  // tests need under a hundred cycles; this limit is far beyond that
  initial begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule : tb_multi_plane_sync_glue
`default_nettype wire
